// file: logic/eeprom_ctl_pkg.sv
// Purpose: Constants and types for the byte-wise storage access controller
// Assumes: APB register access, 32-bit data, one word per register
// Notes: Oscillator rate is a plain default; tick counts derive from it
package eeprom_ctl_pkg;

	// Bus geometry and register byte offsets
	localparam int unsigned BUS_ADDR_W    = 8;
	localparam logic [7:0]  OFS_ADDR      = 8'h00;
	localparam logic [7:0]  OFS_DATA      = 8'h04;
	localparam logic [7:0]  OFS_CTRL      = 8'h08;
	localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0c;
	localparam logic [7:0]  OFS_IRQ_MASK  = 8'h10;

	// Control register field positions
	localparam int unsigned CTRL_READ_BIT = 0;
	localparam int unsigned CTRL_GO_BIT   = 1;
	localparam int unsigned CTRL_ARM_BIT  = 2;
	localparam int unsigned CTRL_MODE_LSB = 4;

	// Event bits in interrupt status and mask
	localparam int unsigned EVT_PROG_DONE = 0;
	localparam int unsigned EVT_READ_DONE = 1;
	localparam int unsigned EVT_W         = 2;

	// Storage size, reset and erased values
	localparam int unsigned STORAGE_DEPTH = 512;
	localparam logic [7:0]  ERASED_BYTE   = 8'hff;
	localparam logic [7:0]  DATA_RESET    = 8'h00;

	// Cycle counts on the processor clock
	localparam logic [2:0]  ARM_WINDOW    = 3'h4;
	localparam logic [2:0]  READ_STALL    = 3'h4;
	localparam logic [2:0]  PROG_STALL    = 3'h2;

	// Self-timed programming on oscillator ticks
	localparam int unsigned TIMER_W        = 24;
	localparam int unsigned ATOMIC_TIME_US = 3400;
	localparam int unsigned OSC_KHZ        = 8000;
	localparam int unsigned ATOMIC_TICKS   = ATOMIC_TIME_US * OSC_KHZ / 1000;

	typedef enum logic [1:0]
	{
		MODE_ATOMIC = 2'h0,
		MODE_ERASE  = 2'h1,
		MODE_WRITE  = 2'h2,
		MODE_RSVD   = 2'h3
	} prog_mode_t;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'h0,
		ST_ERASE = 2'h1,
		ST_WRITE = 2'h3
	} prog_state_t;

endpackage

// file: logic/eeprom_byte_access_controller.sv
// Purpose: Byte read, erase, write and atomic program of on-chip storage
// Assumes: osc_tick is a one-cycle pulse from the calibrated oscillator
// Notes: Stall cycles hold pready low in the pclk cycles right after the starting transfer
module eeprom_byte_access_controller
#(
	parameter int unsigned DEPTH        = eeprom_ctl_pkg::STORAGE_DEPTH,
	parameter int unsigned ATOMIC_TICKS = eeprom_ctl_pkg::ATOMIC_TICKS,
	parameter int unsigned ERASE_TICKS  = eeprom_ctl_pkg::ATOMIC_TICKS / 2,
	parameter int unsigned WRITE_TICKS  = eeprom_ctl_pkg::ATOMIC_TICKS / 2
)
(
	// Clock and reset
	input  wire logic                                  pclk,
	input  wire logic                                  presetn,
	// APB slave
	input  wire logic                                  psel,
	input  wire logic                                  penable,
	input  wire logic                                  pwrite,
	input  wire logic [eeprom_ctl_pkg::BUS_ADDR_W-1:0] paddr,
	input  wire logic [31:0]                           pwdata,
	output logic      [31:0]                           prdata,
	output logic                                       pready,
	output logic                                       pslverr,
	// System side
	input  wire logic                                  osc_tick,
	input  wire logic                                  sys_reset_req,
	output logic                                       cpu_stall,
	output logic                                       irq
);
	import eeprom_ctl_pkg::*;

	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [TIMER_W-1:0] ERASE_LOAD  = TIMER_W'(ERASE_TICKS - 1);
	localparam logic [TIMER_W-1:0] WRITE_LOAD  = TIMER_W'(WRITE_TICKS - 1);
	localparam logic [TIMER_W-1:0] ATOMIC_LOAD = TIMER_W'(ATOMIC_TICKS - WRITE_TICKS - 1);
	localparam logic [TIMER_W-1:0] ATOMIC_LAST = TIMER_W'(ATOMIC_TICKS - 1);
	localparam logic [TIMER_W-1:0] ERASE_LAST  = TIMER_W'(ERASE_TICKS - 1);
	localparam logic [TIMER_W-1:0] WRITE_LAST  = TIMER_W'(WRITE_TICKS - 1);

	logic [7:0]         mem [DEPTH];
	logic [AW-1:0]      addr_q;
	logic [7:0]         data_q;
	prog_mode_t         mode_q;
	prog_state_t        state_q;
	logic [TIMER_W-1:0] timer_q;
	logic [TIMER_W-1:0] tick_cnt_q;
	logic [2:0]         arm_cnt_q;
	logic [2:0]         stall_cnt_q;
	logic [EVT_W-1:0]   status_q;
	logic [EVT_W-1:0]   mask_q;
	logic [31:0]        prdata_q;
	logic [31:0]        rd_mux;
	logic [EVT_W-1:0]   evt_set;
	logic [EVT_W-1:0]   evt_clr;
	logic               hit_addr;
	logic               hit_data;
	logic               hit_ctrl;
	logic               hit_istat;
	logic               hit_imask;
	logic               mapped;
	logic               wr_done;
	logic               rd_done;
	logic               setup_rd;
	logic               ctrl_wr;
	logic               busy;
	logic               arm_active;
	logic               prog_start;
	logic               rd_start;
	logic               phase_end;
	logic               prog_fin;

	// Address decode and APB phases
	assign hit_addr  = (paddr == OFS_ADDR);
	assign hit_data  = (paddr == OFS_DATA);
	assign hit_ctrl  = (paddr == OFS_CTRL);
	assign hit_istat = (paddr == OFS_IRQ_STAT);
	assign hit_imask = (paddr == OFS_IRQ_MASK);
	assign mapped    = hit_addr | hit_data | hit_ctrl | hit_istat | hit_imask;
	assign pready    = (stall_cnt_q == 3'h0);
	assign pslverr   = psel & penable & ~mapped;
	assign wr_done   = psel & penable & pwrite & pready & mapped;
	assign rd_done   = psel & penable & ~pwrite & pready & mapped;
	assign setup_rd  = psel & ~penable & ~pwrite;
	assign prdata    = prdata_q;
	assign cpu_stall = ~pready;

	// Start conditions
	assign busy       = (state_q != ST_IDLE);
	assign arm_active = (arm_cnt_q != 3'h0);
	assign ctrl_wr    = wr_done & hit_ctrl;
	assign prog_start = ctrl_wr & pwdata[CTRL_GO_BIT] & arm_active & ~busy & (mode_q != MODE_RSVD);
	assign rd_start   = ctrl_wr & pwdata[CTRL_READ_BIT] & ~busy & ~prog_start;
	assign phase_end  = osc_tick & (timer_q == '0);
	assign prog_fin   = phase_end & ((state_q == ST_WRITE) | ((state_q == ST_ERASE) & (mode_q == MODE_ERASE)));

	// Arm window
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			arm_cnt_q <= 3'h0;
		else if (prog_start)
			arm_cnt_q <= 3'h0;
		else if (ctrl_wr & pwdata[CTRL_ARM_BIT] & ~busy)
			arm_cnt_q <= ARM_WINDOW;
		else if (arm_active)
			arm_cnt_q <= arm_cnt_q - 3'h1;
	end

	// Mode field
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_q <= MODE_ATOMIC;
		else if (sys_reset_req & ~busy)
			mode_q <= MODE_ATOMIC;
		else if (ctrl_wr & ~busy)
			mode_q <= prog_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
	end

	// Address register, frozen while busy
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			addr_q <= '0;
		else if (wr_done & hit_addr & ~busy)
			addr_q <= pwdata[AW-1:0];
	end

	// Data register, loaded by software or by a read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			data_q <= DATA_RESET;
		else if (rd_start)
			data_q <= mem[addr_q];
		else if (wr_done & hit_data & ~busy)
			data_q <= pwdata[7:0];
	end

	// Programming sequencer on oscillator ticks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ST_IDLE;
			timer_q <= '0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (prog_start && mode_q == MODE_WRITE)
					begin
						state_q <= ST_WRITE;
						timer_q <= WRITE_LOAD;
					end
					else if (prog_start)
					begin
						state_q <= ST_ERASE;
						timer_q <= (mode_q == MODE_ATOMIC) ? ATOMIC_LOAD : ERASE_LOAD;
					end
				end
				ST_ERASE:
				begin
					if (phase_end && mode_q == MODE_ATOMIC)
					begin
						state_q <= ST_WRITE;
						timer_q <= WRITE_LOAD;
					end
					else if (phase_end)
						state_q <= ST_IDLE;
					else if (osc_tick)
						timer_q <= timer_q - 1'b1;
				end
				ST_WRITE:
				begin
					if (phase_end)
						state_q <= ST_IDLE;
					else if (osc_tick)
						timer_q <= timer_q - 1'b1;
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Oscillator tick tally for the timing check
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt_q <= '0;
		else if (prog_start)
			tick_cnt_q <= '0;
		else if (busy & osc_tick)
			tick_cnt_q <= tick_cnt_q + 1'b1;
	end

	// Storage array: erase sets all bits, write can only clear bits
	always_ff @(posedge pclk)
	begin
		if (state_q == ST_ERASE && phase_end)
			mem[addr_q] <= ERASED_BYTE;
		else if (state_q == ST_WRITE && phase_end)
			mem[addr_q] <= mem[addr_q] & data_q;
	end

	// Processor stall counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stall_cnt_q <= 3'h0;
		else if (rd_start)
			stall_cnt_q <= READ_STALL;
		else if (prog_start)
			stall_cnt_q <= PROG_STALL;
		else if (stall_cnt_q != 3'h0)
			stall_cnt_q <= stall_cnt_q - 3'h1;
	end

	// Interrupt status, mask and output
	always_comb
	begin
		evt_set                = '0;
		evt_set[EVT_PROG_DONE] = prog_fin;
		evt_set[EVT_READ_DONE] = rd_start;
		evt_clr                = (rd_done & hit_istat) ? prdata_q[EVT_W-1:0] : '0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_q <= '0;
		else
			status_q <= (status_q & ~evt_clr) | evt_set;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_q <= '0;
		else if (wr_done & hit_imask)
			mask_q <= pwdata[EVT_W-1:0];
	end

	assign irq = |(status_q & mask_q);

	// Read data, captured in the setup cycle
	always_comb
	begin
		rd_mux = '0;
		if (hit_addr)
			rd_mux[AW-1:0] = addr_q;
		if (hit_data)
			rd_mux[7:0] = data_q;
		if (hit_ctrl)
		begin
			rd_mux[CTRL_MODE_LSB +: 2] = mode_q;
			rd_mux[CTRL_ARM_BIT]       = arm_active;
			rd_mux[CTRL_GO_BIT]        = busy;
		end
		if (hit_istat)
			rd_mux[EVT_W-1:0] = status_q;
		if (hit_imask)
			rd_mux[EVT_W-1:0] = mask_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= '0;
		else if (setup_rd)
			prdata_q <= rd_mux;
	end

	// Checks
	a_read_stall: assert property (@(posedge pclk) disable iff (!presetn)
		rd_start |=> cpu_stall [*4] ##1 !cpu_stall)
		else $error("read stall not four cycles");

	a_prog_stall: assert property (@(posedge pclk) disable iff (!presetn)
		prog_start |=> cpu_stall [*2] ##1 !cpu_stall)
		else $error("program stall not two cycles");

	a_start_busy: assert property (@(posedge pclk) disable iff (!presetn)
		prog_start |=> busy && !pready)
		else $error("program start did not set busy");

	a_no_overlap: assert property (@(posedge pclk) disable iff (!presetn)
		busy |-> !rd_start && !prog_start && $stable(addr_q))
		else $error("operation accepted while busy");

	a_arm_needed: assert property (@(posedge pclk) disable iff (!presetn)
		prog_start |-> $past(arm_active) && arm_active)
		else $error("program started without arm");

	a_arm_expire: assert property (@(posedge pclk) disable iff (!presetn)
		(arm_cnt_q == 3'h1 && !ctrl_wr) |=> !arm_active)
		else $error("arm window not closed");

	a_arm_span: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_wr && pwdata[CTRL_ARM_BIT] && !busy && !prog_start) |=> arm_cnt_q == ARM_WINDOW)
		else $error("arm window not loaded to four");

	a_mode_lock: assert property (@(posedge pclk) disable iff (!presetn)
		busy |=> $stable(mode_q))
		else $error("mode changed while busy");

	a_mode_reset: assert property (@(posedge pclk) disable iff (!presetn)
		(sys_reset_req && !busy) |=> mode_q == MODE_ATOMIC)
		else $error("mode not cleared by system reset");

	a_read_data: assert property (@(posedge pclk) disable iff (!presetn)
		rd_start |=> data_q == mem[$past(addr_q)])
		else $error("read data mismatch");

	a_erase_value: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_ERASE && phase_end) |=> mem[addr_q] == ERASED_BYTE)
		else $error("erase did not set byte");

	a_atomic_done: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_ERASE && phase_end && mode_q == MODE_ATOMIC) |=> busy && state_q == ST_WRITE)
		else $error("atomic program dropped busy after erase");

	a_tick_only: assert property (@(posedge pclk) disable iff (!presetn)
		(busy && !osc_tick) |=> $stable(timer_q) && $stable(state_q))
		else $error("timer moved without oscillator tick");

	a_prog_time: assert property (@(posedge pclk) disable iff (!presetn)
		prog_fin |-> tick_cnt_q == ((mode_q == MODE_ATOMIC) ? ATOMIC_LAST :
			(mode_q == MODE_ERASE) ? ERASE_LAST : WRITE_LAST))
		else $error("programming time not as configured");

endmodule

// file: tb/eeprom_byte_access_controller_tb_top.sv
// Purpose: Self-checking bench for the byte storage access controller
// Assumes: Short tick counts; osc_tick pulses every second pclk cycle
// Notes: Every location is erased or programmed before it is read
module eeprom_byte_access_controller_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import eeprom_ctl_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        osc_tick;
	logic        osc_en;
	logic        sys_reset_req;
	logic        cpu_stall;
	logic        irq;
	logic [31:0] r;
	logic        se;
	logic        iq;
	int          st;
	int          n_fail;
	int          checks;

	eeprom_byte_access_controller #(.ATOMIC_TICKS(8), .ERASE_TICKS(4), .WRITE_TICKS(4)) dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_tick(osc_tick), .sys_reset_req(sys_reset_req), .cpu_stall(cpu_stall), .irq(irq)
	);

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Oscillator ticks, stoppable
	always @(posedge pclk)
		osc_tick <= presetn & osc_en & ~osc_tick;

	task automatic give_verdict();
		if (n_fail == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer, request held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 100);
		r = prdata;
		se = pslverr;
		if (k >= 100)
			n_fail++;
	endtask

	// Bus idle; counts stall cycles
	task automatic idle(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		st = 0;
		repeat (n)
		begin
			#1;
			if (cpu_stall === 1'b1)
				st++;
			iq = irq;
			@(posedge pclk);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		idle(1);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		idle(1);
	endtask

	task automatic wait_idle();
		int k;
		k = 0;
		do
		begin
			rd(OFS_CTRL);
			k++;
		end
		while (r[CTRL_GO_BIT] !== 1'b0 && k < 200);
		chk(k < 200, 1'b1);
	endtask

	// Arm, go, then probe while the oscillator is stopped
	task automatic start(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
		wr(OFS_ADDR, {23'h0, a});
		wr(OFS_DATA, {24'h0, d});
		wr(OFS_CTRL, {26'h0, m, 4'h0});
		wr(OFS_CTRL, {26'h0, m, 4'h4});
		osc_en <= 1'b0;
		apb(1'b1, OFS_CTRL, {26'h0, m, 4'h6});
		idle(8);
		chk(st, PROG_STALL);
		rd(OFS_CTRL);
		chk(r[CTRL_GO_BIT], 1'b1);
		wr(OFS_CTRL, 32'h31);
		wr(OFS_ADDR, {23'h0, a ^ 9'h001});
		osc_en <= 1'b1;
		wait_idle();
		rd(OFS_ADDR);
		chk(r, {23'h0, a});
		rd(OFS_CTRL);
		chk(r[5:4], m);
	endtask

	task automatic rdb(input logic [8:0] a, input logic [7:0] d);
		wr(OFS_ADDR, {23'h0, a});
		apb(1'b1, OFS_CTRL, 32'h1);
		idle(8);
		chk(st, READ_STALL);
		rd(OFS_DATA);
		chk(r, {24'h0, d});
	endtask

	task automatic t_regs();
		rd(OFS_DATA);
		chk(r, {24'h0, DATA_RESET});
		wr(OFS_ADDR, 32'h1a5);
		rd(OFS_ADDR);
		chk(r, 32'h1a5);
		apb(1'b1, 8'h40, 32'h1);
		chk(se, 1'b1);
		idle(1);
		wr(OFS_CTRL, 32'h2);
		rd(OFS_CTRL);
		chk(r[CTRL_GO_BIT], 1'b0);
	endtask

	task automatic t_modes();
		start(MODE_ERASE, 9'h005, 8'h00);
		rdb(9'h005, ERASED_BYTE);
		start(MODE_WRITE, 9'h005, 8'h5a);
		rdb(9'h005, 8'h5a);
		start(MODE_WRITE, 9'h005, 8'h0f);
		rdb(9'h005, 8'h0a);
	endtask

	task automatic t_irq();
		wr(OFS_IRQ_MASK, 32'h0);
		rd(OFS_IRQ_STAT);
		start(MODE_ATOMIC, 9'h1f0, 8'h3c);
		chk(iq, 1'b0);
		rdb(9'h1f0, 8'h3c);
		wr(OFS_IRQ_MASK, 32'h1);
		chk(iq, 1'b1);
		rd(OFS_IRQ_STAT);
		chk(r[EVT_PROG_DONE], 1'b1);
		chk(iq, 1'b0);
	endtask

	task automatic t_arm();
		wr(OFS_CTRL, 32'h4);
		idle(6);
		wr(OFS_CTRL, 32'h2);
		rd(OFS_CTRL);
		chk(r[CTRL_GO_BIT], 1'b0);
	endtask

	task automatic t_rst();
		wr(OFS_CTRL, 32'h10);
		sys_reset_req <= 1'b1;
		idle(2);
		sys_reset_req <= 1'b0;
		rd(OFS_CTRL);
		chk(r[5:4], 2'h0);
		wr(OFS_CTRL, 32'h24);
		osc_en <= 1'b0;
		wr(OFS_CTRL, 32'h26);
		sys_reset_req <= 1'b1;
		idle(2);
		sys_reset_req <= 1'b0;
		rd(OFS_CTRL);
		chk(r[5:4], 2'h2);
		osc_en <= 1'b1;
		wait_idle();
	endtask

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		osc_en = 1'b1;
		sys_reset_req = 1'b0;
		n_fail = 0;
		checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_modes();
		t_irq();
		t_arm();
		t_rst();
		give_verdict();
	end

	// Watchdog
	initial
	begin
		#200000;
		n_fail++;
		give_verdict();
	end
endmodule
